// ===== core/ppfs_defines.svh
// Constants for the port pin function select block: offsets, field positions, counts.
// Assumes inclusion by bare name from the core/ files.
`ifndef PPFS_DEFINES_SVH
`define PPFS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PPFS_ADDR_W          8
`define PPFS_OFF_PA_DATA     8'h30
`define PPFS_OFF_PA_DIR      8'h31
`define PPFS_OFF_PB_DATA     8'h32
`define PPFS_OFF_PB_DIR      8'h33
`define PPFS_OFF_PB_FUNC     8'h34
`define PPFS_OFF_PA_PULL     8'h35
`define PPFS_OFF_PB0_PULL    8'h36
`define PPFS_OFF_IRQ_CTRL0   8'h37
`define PPFS_OFF_SER_CTRL    8'h38
`define PPFS_OFF_SEG_SEL     8'h39
`define PPFS_OFF_PB_PULL     8'h3A
`define PPFS_OFF_PA_PIN      8'h3B
`define PPFS_OFF_PB_PIN      8'h3C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPFS_IRQ_EXT_EN_BIT  1
`define PPFS_IRQ_ENA_BIT     0
`define PPFS_IRQ_PEND_BIT    4
`define PPFS_FUNC_SIN_BIT    2
`define PPFS_FUNC_SOUT_BIT   1
`define PPFS_FUNC_SCLK_BIT   0
`define PPFS_SER_START_BIT   0
`define PPFS_SER_BUSY_BIT    7
`define PPFS_PB_IRQ_BIT      3
`define PPFS_PB_SIN_BIT      2
`define PPFS_PB_SOUT_BIT     1
`define PPFS_PB_SCLK_BIT     0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PPFS_RST_BYTE        8'h00
`define PPFS_SCLK_PULSES     4'h8
`define PPFS_SCLK_HALF       4'h4
`define PPFS_IRQ_VECTOR      15'h0004
`define PPFS_STACK_DEPTH     4'h8

`endif

// ===== core/ppfs_pkg.sv
// Types for the port pin function select block.
// Assumes nothing beyond a SystemVerilog compiler.
package ppfs_pkg;
    typedef enum logic [2:0] {
        SCK_IDLE = 3'h1,
        SCK_LOW  = 3'h2,
        SCK_HIGH = 3'h4
    } ppfs_sck_t;
endpackage : ppfs_pkg

// ===== core/ppfs_edge_det.sv
// Falling edge detector for a synchronous pin input, gated by an enable.
// Assumes the pin is already synchronous to core_clk.
`timescale 1ns/10ps
module ppfs_edge_det (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic enable,
    input  wire logic pinIn,
    output logic      fallPulse
);
    typedef struct packed {
        logic prev;
    } ppfs_edge_st_t;

    ppfs_edge_st_t stFf;
    ppfs_edge_st_t nxtSt;

    always_comb begin
        nxtSt      = stFf;
        nxtSt.prev = pinIn;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stFf <= '{prev: 1'b1};
        end else begin
            stFf <= nxtSt;
        end
    end

    // Level alone never fires; outside irq mode edges are ignored
    assign fallPulse = enable & stFf.prev & ~pinIn; // RL5 RL6
endmodule : ppfs_edge_det

// ===== core/ppfs_sclk_gen.sv
// Serial clock generator: exactly eight pulses per start, then stops.
// Assumes start is a one-cycle pulse from the register block.
`timescale 1ns/10ps
`include "ppfs_defines.svh"
module ppfs_sclk_gen #(
    parameter int HALF_W = 4
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              start,
    input  wire logic [HALF_W-1:0] halfCycles,
    output logic                   sclkOut,
    output logic                   busy,
    output logic                   sampleStb
);
    typedef struct packed {
        ppfs_pkg::ppfs_sck_t state;
        logic [3:0]          pulses;
        logic [HALF_W-1:0]   cnt;
        logic                sclk;
    } ppfs_sck_st_t;

    ppfs_sck_st_t stFf;
    ppfs_sck_st_t nxtSt;
    logic         halfDone;

    if (HALF_W < 1) begin : g_bad_half
        $error("HALF_W must be at least 1");
    end

    assign halfDone = (stFf.cnt == halfCycles);

    always_comb begin
        nxtSt     = stFf;
        sampleStb = 1'b0;
        case (stFf.state)
            ppfs_pkg::SCK_IDLE: begin
                nxtSt.sclk = 1'b1;
                if (start) begin
                    nxtSt.state  = ppfs_pkg::SCK_LOW;
                    nxtSt.pulses = 4'h0;
                    nxtSt.cnt    = '0;
                    nxtSt.sclk   = 1'b0;
                end
            end
            ppfs_pkg::SCK_LOW: begin
                nxtSt.cnt = stFf.cnt + 1'b1;
                if (halfDone) begin
                    nxtSt.state = ppfs_pkg::SCK_HIGH;
                    nxtSt.cnt   = '0;
                    nxtSt.sclk  = 1'b1;
                    sampleStb   = 1'b1;
                end
            end
            ppfs_pkg::SCK_HIGH: begin
                nxtSt.cnt = stFf.cnt + 1'b1;
                if (halfDone) begin
                    nxtSt.cnt    = '0;
                    nxtSt.pulses = stFf.pulses + 4'h1;
                    // Suspend on its own after the eighth pulse
                    if (stFf.pulses + 4'h1 == `PPFS_SCLK_PULSES) begin // RL10
                        nxtSt.state = ppfs_pkg::SCK_IDLE;
                    end else begin
                        nxtSt.state = ppfs_pkg::SCK_LOW;
                        nxtSt.sclk  = 1'b0;
                    end
                end
            end
            default: begin
                nxtSt.state = ppfs_pkg::SCK_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stFf <= '{state: ppfs_pkg::SCK_IDLE, pulses: 4'h0, cnt: '0, sclk: 1'b1};
        end else begin
            stFf <= nxtSt;
        end
    end

    assign sclkOut = stFf.sclk;
    assign busy    = (stFf.state != ppfs_pkg::SCK_IDLE);
endmodule : ppfs_sclk_gen

// ===== core/ppfs_top.sv
// Port pin function select: port A, port B function muxing, low segment lines.
// Assumes synchronous pin inputs and a register master that never waits.
`timescale 1ns/10ps
`include "ppfs_defines.svh"

// What this block does
// RL1 - Port A bits each output or input, pull-ups from port_a_pullup_ctrl
// RL2 - Port A wake-up per bit chosen by build parameter
// RL3 - Port B bits 4 and 5 are bidirectional with software pull-up
// RL4 - Irq control bit 1 turns port B bit 3 into irq input
// RL5 - External irq request on falling edge only, never on level
// RL6 - Port B bit 3 in I/O mode raises no irq
// RL7 - Port B bit 2 is I/O or serial input without pull-up
// RL8 - Port B bit 1 is I/O or push-pull serial output
// RL9 - Port B bit 0 is I/O or serial clock; pull-up via port_b_bit0_pullup_ctrl
// RL10 - Serial clock stops after exactly eight pulses
// RL11 - Four low segment lines drive LCD or keyscan strobes
// RL12 - External circuit drives active-low reset to reset chip
// RL13 - Accepted irq vectors to 004H if enabled and stack not full
module ppfs_top #(
    parameter logic [7:0] WAKE_MASK = 8'h00,
    parameter int         SEG_N     = 4,
    parameter int         HALF_W    = 4
) (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire logic [`PPFS_ADDR_W-1:0]  regAddr,
    input  wire logic [7:0]               regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [7:0]               regRdata,
    input  wire logic [7:0]               portALinesIn,
    output logic      [7:0]               portALinesOut,
    output logic      [7:0]               portALinesOe,
    output logic      [7:0]               portALinesPull,
    output logic                          wakeReq,
    input  wire logic [5:0]               portBIn,
    output logic      [5:0]               portBOut,
    output logic      [5:0]               portBOe,
    output logic      [5:0]               portBPull,
    input  wire logic [SEG_N-1:0]         lcdSegDrive,
    input  wire logic [SEG_N-1:0]         keyStrobe,
    output logic      [SEG_N-1:0]         lcdDriveLinesLow,
    input  wire logic                     serialTxBit,
    output logic                          serialRxBit,
    output logic                          serialSampleStb,
    input  wire logic [3:0]               stackLevel,
    input  wire logic                     irqAck,
    output logic                          irqVectorReq,
    output logic      [14:0]              irqVectorAddr
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]        paData;
        logic [7:0]        paDir;
        logic [7:0]        paPull;
        logic [5:0]        pbData;
        logic [5:0]        pbDir;
        logic [5:0]        pbPull;
        logic [7:0]        pb0Pull;
        logic [2:0]        pbFunc;
        logic [7:0]        irqCtrl0;
        logic [SEG_N-1:0]  segSel;
        logic [7:0]        paPinPrev;
        logic [7:0]        rdata;
        logic              serStart;
    } ppfs_top_st_t;

    ppfs_top_st_t stFf;
    ppfs_top_st_t nxtSt;
    logic         sclkOut;
    logic         serBusy;
    logic         extFall;
    logic         irqMode;
    logic         stackFull;

    if (SEG_N < 1 || SEG_N > 8) begin : g_bad_seg
        $error("SEG_N must be 1 to 8");
    end
    // The half-period count is cut to HALF_W bits, so it must fit
    if ((1 << HALF_W) <= int'(`PPFS_SCLK_HALF)) begin : g_bad_half
        $error("HALF_W too narrow for the half-period count");
    end

    function automatic logic isReg(input logic [`PPFS_ADDR_W-1:0] a,
                                   input logic [`PPFS_ADDR_W-1:0] off);
        isReg = (a == off);
    endfunction : isReg

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    assign irqMode = stFf.irqCtrl0[`PPFS_IRQ_EXT_EN_BIT]; // RL4

    ppfs_edge_det u_edge (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .enable    (irqMode),
        .pinIn     (portBIn[`PPFS_PB_IRQ_BIT]),
        .fallPulse (extFall)
    );

    ppfs_sclk_gen #(.HALF_W(HALF_W)) u_sclk (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .start      (stFf.serStart),
        .halfCycles (HALF_W'(`PPFS_SCLK_HALF)),
        .sclkOut    (sclkOut),
        .busy       (serBusy),
        .sampleStb  (serialSampleStb)
    );

    assign stackFull = (stackLevel >= `PPFS_STACK_DEPTH);

    // ----------------------------------------
    // Register file and events
    // ----------------------------------------
    always_comb begin
        nxtSt           = stFf;
        nxtSt.serStart  = 1'b0;
        nxtSt.paPinPrev = portALinesIn;
        nxtSt.rdata     = `PPFS_RST_BYTE;
        if (regWr) begin
            if (isReg(regAddr, `PPFS_OFF_PA_DATA))   nxtSt.paData = regWdata;
            if (isReg(regAddr, `PPFS_OFF_PA_DIR))    nxtSt.paDir = regWdata;
            if (isReg(regAddr, `PPFS_OFF_PA_PULL))   nxtSt.paPull = regWdata; // RL1
            if (isReg(regAddr, `PPFS_OFF_PB_DATA))   nxtSt.pbData = regWdata[5:0];
            if (isReg(regAddr, `PPFS_OFF_PB_DIR))    nxtSt.pbDir = regWdata[5:0];
            if (isReg(regAddr, `PPFS_OFF_PB_PULL))   nxtSt.pbPull = regWdata[5:0]; // RL3
            if (isReg(regAddr, `PPFS_OFF_PB0_PULL))  nxtSt.pb0Pull = regWdata; // RL9
            if (isReg(regAddr, `PPFS_OFF_PB_FUNC))   nxtSt.pbFunc = regWdata[2:0];
            if (isReg(regAddr, `PPFS_OFF_SEG_SEL))   nxtSt.segSel = regWdata[SEG_N-1:0]; // RL11
            if (isReg(regAddr, `PPFS_OFF_IRQ_CTRL0)) begin
                // Pending bit is write-one-to-clear; other bits plain
                nxtSt.irqCtrl0 = regWdata;
                nxtSt.irqCtrl0[`PPFS_IRQ_PEND_BIT] = stFf.irqCtrl0[`PPFS_IRQ_PEND_BIT]
                    & ~regWdata[`PPFS_IRQ_PEND_BIT];
            end
            if (isReg(regAddr, `PPFS_OFF_SER_CTRL) && regWdata[`PPFS_SER_START_BIT]
                && stFf.pbFunc[`PPFS_FUNC_SCLK_BIT] && !serBusy) begin
                nxtSt.serStart = 1'b1;
            end
        end
        // Acknowledge drops pending; a new edge in the same cycle wins
        if (irqAck) nxtSt.irqCtrl0[`PPFS_IRQ_PEND_BIT] = 1'b0;
        if (extFall) nxtSt.irqCtrl0[`PPFS_IRQ_PEND_BIT] = 1'b1; // RL5
        if (regRd) begin
            case (regAddr)
                `PPFS_OFF_PA_DATA:   nxtSt.rdata = stFf.paData;
                `PPFS_OFF_PA_DIR:    nxtSt.rdata = stFf.paDir;
                `PPFS_OFF_PA_PULL:   nxtSt.rdata = stFf.paPull;
                `PPFS_OFF_PB_DATA:   nxtSt.rdata = {2'h0, stFf.pbData};
                `PPFS_OFF_PB_DIR:    nxtSt.rdata = {2'h0, stFf.pbDir};
                `PPFS_OFF_PB_PULL:   nxtSt.rdata = {2'h0, stFf.pbPull};
                `PPFS_OFF_PB0_PULL:  nxtSt.rdata = stFf.pb0Pull;
                `PPFS_OFF_PB_FUNC:   nxtSt.rdata = {5'h00, stFf.pbFunc};
                `PPFS_OFF_IRQ_CTRL0: nxtSt.rdata = stFf.irqCtrl0;
                `PPFS_OFF_SER_CTRL:  nxtSt.rdata = {serBusy, 7'h00};
                `PPFS_OFF_SEG_SEL:   nxtSt.rdata = 8'(stFf.segSel);
                `PPFS_OFF_PA_PIN:    nxtSt.rdata = portALinesIn;
                `PPFS_OFF_PB_PIN:    nxtSt.rdata = {2'h0, portBIn};
                default:             nxtSt.rdata = `PPFS_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        // Chip clear is active low and asynchronous
        if (!nrst) begin // RL12
            stFf <= '0;
        end else begin
            stFf <= nxtSt;
        end
    end

    assign regRdata = stFf.rdata;

    // ----------------------------------------
    // Port A
    // ----------------------------------------
    // Outputs are push-pull; inputs get pull-up only when selected
    assign portALinesOut  = stFf.paData; // RL1
    assign portALinesOe   = stFf.paDir; // RL1
    assign portALinesPull = stFf.paPull & ~stFf.paDir; // RL1
    // Wake-up lines fixed at build time; any falling masked input wakes
    assign wakeReq = |(WAKE_MASK & ~stFf.paDir & stFf.paPinPrev & ~portALinesIn); // RL2

    // ----------------------------------------
    // Port B muxing
    // ----------------------------------------
    always_comb begin
        portBOut  = stFf.pbData;
        portBOe   = stFf.pbDir; // RL3
        portBPull = stFf.pbPull & ~stFf.pbDir; // RL3
        portBPull[`PPFS_PB_SCLK_BIT] = stFf.pb0Pull[0] & ~stFf.pbDir[`PPFS_PB_SCLK_BIT]; // RL9
        if (irqMode) begin
            portBOe[`PPFS_PB_IRQ_BIT] = 1'b0; // RL4
        end
        if (stFf.pbFunc[`PPFS_FUNC_SIN_BIT]) begin
            portBOe[`PPFS_PB_SIN_BIT]   = 1'b0; // RL7
            portBPull[`PPFS_PB_SIN_BIT] = 1'b0; // RL7
        end
        if (stFf.pbFunc[`PPFS_FUNC_SOUT_BIT]) begin
            portBOut[`PPFS_PB_SOUT_BIT]  = serialTxBit; // RL8
            portBOe[`PPFS_PB_SOUT_BIT]   = 1'b1; // RL8
            portBPull[`PPFS_PB_SOUT_BIT] = 1'b0;
        end
        if (stFf.pbFunc[`PPFS_FUNC_SCLK_BIT]) begin
            portBOut[`PPFS_PB_SCLK_BIT]  = sclkOut; // RL10
            portBOe[`PPFS_PB_SCLK_BIT]   = 1'b1; // RL9
            portBPull[`PPFS_PB_SCLK_BIT] = 1'b0;
        end
    end

    assign serialRxBit = stFf.pbFunc[`PPFS_FUNC_SIN_BIT] & portBIn[`PPFS_PB_SIN_BIT]; // RL7

    // ----------------------------------------
    // Low segment lines
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SEG_N; gi++) begin : g_seg
            assign lcdDriveLinesLow[gi] = stFf.segSel[gi] ? keyStrobe[gi] : lcdSegDrive[gi]; // RL11
        end
    endgenerate

    // ----------------------------------------
    // Vector request
    // ----------------------------------------
    // Held until acknowledged or cleared by writing one to the pending bit; a full stack simply defers it
    assign irqVectorReq = stFf.irqCtrl0[`PPFS_IRQ_PEND_BIT]
                        & stFf.irqCtrl0[`PPFS_IRQ_ENA_BIT] & ~stackFull; // RL13
    assign irqVectorAddr = `PPFS_IRQ_VECTOR; // RL13
endmodule : ppfs_top

// ===== verif/ppfs_assertions.sv
// Checker for the port pin function select block, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset nrst.
`timescale 1ns/10ps
module ppfs_assertions #(
    parameter int         SEG_N     = 4,
    parameter logic [7:0] WAKE_MASK = 8'h00
) (
    input wire logic             core_clk,
    input wire logic             nrst,
    input wire logic             regWr,
    input wire logic             regRd,
    input wire logic [7:0]       regRdata,
    input wire logic [7:0]       portALinesIn,
    input wire logic [7:0]       portALinesOe,
    input wire logic [7:0]       portALinesPull,
    input wire logic             wakeReq,
    input wire logic [5:0]       portBIn,
    input wire logic [5:0]       portBOe,
    input wire logic [5:0]       portBPull,
    input wire logic [SEG_N-1:0] lcdSegDrive,
    input wire logic [SEG_N-1:0] keyStrobe,
    input wire logic [SEG_N-1:0] lcdDriveLinesLow,
    input wire logic             serialRxBit,
    input wire logic [3:0]       stackLevel,
    input wire logic             irqVectorReq,
    input wire logic [14:0]      irqVectorAddr
);
    // ----------------------------------------
    // Pin and request relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_pull_input_only: assert property ((portALinesPull & portALinesOe) == 8'h00)
        else $error("pull-up on a driven port A bit");
    a_wake_masked_fall: assert property (
        wakeReq |-> (WAKE_MASK & $past(portALinesIn) & ~portALinesIn) != 8'h00)
        else $error("wake request without a masked falling edge");
    a_pb_pull_input: assert property ((portBPull & portBOe) == 6'h00)
        else $error("pull-up on a driven port B bit");
    // Enable writes and stack changes can also raise the request, so they are excluded
    a_irq_from_fall: assert property (
        $rose(irqVectorReq) && $stable(stackLevel) && !$past(regWr)
        |-> $past(portBIn[3], 2) && !$past(portBIn[3]))
        else $error("irq request without a falling edge");
    a_sin_no_pull: assert property (serialRxBit |-> !portBPull[2] && !portBOe[2])
        else $error("serial input pin pulled or driven");
    a_seg_source: assert property (
        ((lcdDriveLinesLow ^ lcdSegDrive) & (lcdDriveLinesLow ^ keyStrobe)) == '0)
        else $error("segment line from neither source");
    a_vec_stack_full: assert property (irqVectorReq |-> stackLevel < 4'h8)
        else $error("vector request with full stack");
    a_vec_address: assert property (irqVectorAddr == 15'h0004)
        else $error("wrong vector address");
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : ppfs_assertions

// ===== verif/ppfs_pin_model.sv
// External pins: switches and serial devices hanging on one port.
// Assumes the bench steers each pin through extEn and extVal.
`timescale 1ns/10ps
module ppfs_pin_model #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] drv,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] extEn,
    input  wire logic [W-1:0] extVal,
    output logic      [W-1:0] pin
);
    // ----------------------------------------
    // Pin resolution
    // ----------------------------------------
    logic [W-1:0] last_ff = '0;
    always_ff @(posedge core_clk) begin
        last_ff <= pin;
    end
    // A floating pin without pull-up toggles, so nothing may rely on a stale level
    always_comb begin
        for (int k = 0; k < W; k++) begin
            if (oe[k]) pin[k] = drv[k];
            else if (extEn[k]) pin[k] = extVal[k];
            else if (pull[k]) pin[k] = 1'b1;
            else pin[k] = ~last_ff[k];
        end
    end
endmodule : ppfs_pin_model

// ===== verif/testbench.sv
// Self-checking bench for the port pin function select block.
// Assumes the checker and pin model files are compiled before it.
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam logic [7:0] WAKE_MASK = 8'h5A;
    logic        core_clk, nrst, regWr, regRd, wakeReq, serialTxBit, serialRxBit;
    logic        serialSampleStb, irqAck, irqVectorReq, last;
    logic [7:0]  regAddr, regWdata, regRdata, paIn, paOut, paOe, paPull, paExtVal, d, e, p, q;
    logic [5:0]  pbIn, pbOut, pbOe, pbPull, pbExtVal;
    logic [3:0]  lcdSeg, keyStb, segOut, stackLevel;
    logic [14:0] vecAddr;
    int          errCount, checked, cycles, seed, i, n, r;

    ppfs_top #(.WAKE_MASK(WAKE_MASK)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portALinesIn(paIn),
        .portALinesOut(paOut), .portALinesOe(paOe), .portALinesPull(paPull),
        .wakeReq(wakeReq), .portBIn(pbIn), .portBOut(pbOut), .portBOe(pbOe),
        .portBPull(pbPull), .lcdSegDrive(lcdSeg), .keyStrobe(keyStb),
        .lcdDriveLinesLow(segOut), .serialTxBit(serialTxBit), .serialRxBit(serialRxBit),
        .serialSampleStb(serialSampleStb), .stackLevel(stackLevel), .irqAck(irqAck),
        .irqVectorReq(irqVectorReq), .irqVectorAddr(vecAddr));
    ppfs_pin_model #(.W(8)) pa_u (.core_clk(core_clk), .oe(paOe), .drv(paOut),
        .pull(paPull), .extEn(8'hFF), .extVal(paExtVal), .pin(paIn));
    ppfs_pin_model #(.W(6)) pb_u (.core_clk(core_clk), .oe(pbOe), .drv(pbOut),
        .pull(pbPull), .extEn(6'h3F), .extVal(pbExtVal), .pin(pbIn));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Generous ceiling: the sequence needs well under two thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount++;
            printVerdict();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Per-bit select: where sel is set take a, else b
    function automatic logic [7:0] mixBits(input logic [7:0] sel, input logic [7:0] a,
                                           input logic [7:0] b);
        mixBits = (sel & a) | (~sel & b);
    endfunction : mixBits
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        v = regRdata;
    endtask : rd
    task automatic fallB3();
        @(posedge core_clk) pbExtVal[3] <= 1'b1;
        @(posedge core_clk) pbExtVal[3] <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : fallB3
    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : printVerdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {regWr, regRd, serialTxBit, irqAck, regAddr, regWdata, lcdSeg, keyStb} = '0;
        {errCount, checked, cycles, stackLevel} = '0;
        paExtVal = 8'hFF;
        pbExtVal = 6'h3F;
        seed = 32'hE468CB31;
        nrst = 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        for (n = 8'h30; n <= 8'h3A; n++) begin
            rd(n[7:0], d);
            chk(d, 8'h00);
        end
        rd(8'h50, d);
        chk(d, 8'h00);
        for (i = 0; i < 6; i++) begin
            e = (i == 0) ? 8'h00 : $random(seed);
            d = $random(seed);
            p = $random(seed);
            wr(8'h31, e);
            wr(8'h30, d);
            wr(8'h35, p);
            paExtVal <= $random(seed);
            @(negedge core_clk);
            chk(paOe, e);
            chk(paOut & e, d & e);
            chk(paPull, p & ~e);
            rd(8'h3B, q);
            chk(q, mixBits(e, d, paExtVal));
            rd(8'h35, d);
            chk(d, p);
        end
        e = $random(seed);
        p = $random(seed);
        wr(8'h33, {2'b00, e[5:0]});
        wr(8'h3A, {2'b00, p[5:1], 1'b0});
        wr(8'h36, 8'h01);
        @(negedge core_clk);
        chk(pbOe, e[5:0]);
        chk(pbPull[5:4], p[5:4] & ~e[5:4]);
        chk(pbPull[0], !e[0]);
        wr(8'h33, 8'h00);
        wr(8'h37, 8'h01);
        fallB3();
        chk(irqVectorReq, 1'b0);
        wr(8'h37, 8'h03);
        repeat (3) @(negedge core_clk);
        chk(irqVectorReq, 1'b0);
        fallB3();
        chk(irqVectorReq, 1'b1);
        chk(vecAddr, 15'h0004);
        @(posedge core_clk) stackLevel <= 4'h8;
        @(negedge core_clk) chk(irqVectorReq, 1'b0);
        @(posedge core_clk) stackLevel <= 4'h7;
        @(negedge core_clk) chk(irqVectorReq, 1'b1);
        @(posedge core_clk) irqAck <= 1'b1;
        @(posedge core_clk) irqAck <= 1'b0;
        @(negedge core_clk) chk(irqVectorReq, 1'b0);
        fallB3();
        rd(8'h37, d);
        chk(d, 8'h13);
        wr(8'h37, 8'h13);
        @(negedge core_clk) chk(irqVectorReq, 1'b0);
        wr(8'h3A, 8'h04);
        wr(8'h34, 8'h07);
        // Serial input held high so the no-pull check has something to watch
        pbExtVal <= 6'($random(seed)) | 6'h04;
        @(negedge core_clk);
        chk(pbPull[2], 1'b0);
        chk(serialRxBit, pbExtVal[2]);
        chk(pbOe[1:0], 2'h3);
        for (n = 0; n < 2; n++) begin
            @(posedge core_clk) serialTxBit <= n[0];
            repeat (2) @(negedge core_clk);
            chk(pbOut[1], n[0]);
        end
        wr(8'h38, 8'h01);
        rd(8'h38, d);
        chk(d[7], 1'b1);
        {n, r, last} = '0;
        repeat (200) begin
            @(negedge core_clk);
            if (serialSampleStb === 1'b1) n++;
            if (pbOut[0] === 1'b1 && last === 1'b0) r++;
            last = pbOut[0];
        end
        chk(n[15:0], 16'h0008);
        chk(r[15:0], 16'h0008);
        chk(pbOut[0], 1'b1);
        wr(8'h34, 8'h00);
        @(negedge core_clk) chk(serialRxBit, 1'b0);
        for (i = 0; i < 8; i++) begin
            p = $random(seed);
            wr(8'h39, p);
            lcdSeg <= $random(seed);
            keyStb <= $random(seed);
            @(negedge core_clk);
            chk(segOut, mixBits(p, keyStb, lcdSeg));
        end
        wr(8'h31, 8'h00);
        paExtVal <= 8'hFF;
        repeat (2) @(posedge core_clk);
        for (i = 0; i < 8; i++) begin
            @(posedge core_clk) paExtVal[i] <= 1'b0;
            @(negedge core_clk) chk(wakeReq, WAKE_MASK[i]);
            @(posedge core_clk) paExtVal[i] <= 1'b1;
        end
        printVerdict();
    end
endmodule : testbench

bind ppfs_top ppfs_assertions #(.SEG_N(SEG_N), .WAKE_MASK(WAKE_MASK)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .portALinesIn(portALinesIn), .portALinesOe(portALinesOe),
    .portALinesPull(portALinesPull), .wakeReq(wakeReq), .portBIn(portBIn),
    .portBOe(portBOe), .portBPull(portBPull), .lcdSegDrive(lcdSegDrive),
    .keyStrobe(keyStrobe), .lcdDriveLinesLow(lcdDriveLinesLow),
    .serialRxBit(serialRxBit), .stackLevel(stackLevel), .irqVectorReq(irqVectorReq),
    .irqVectorAddr(irqVectorAddr));
